// ==== design/msc_pkg.sv ====
// Constants for the meter status condition bank: bit positions, selects, reset values.
package msc_pkg;
    // Operation status group bit positions.
    localparam int OP_CAL_BIT = 0;
    localparam int OP_MEAS_BIT = 4;
    localparam int OP_TRIG_BIT = 5;
    localparam int OP_SENSE_BIT = 10;
    localparam int OP_LOWER_BIT = 11;
    localparam int OP_UPPER_BIT = 12;
    // Device status group bit positions.
    localparam int DEV_CONN_A_BIT = 1;
    localparam int DEV_CONN_B_BIT = 2;
    localparam int DEV_ERR_A_BIT = 3;
    localparam int DEV_ERR_B_BIT = 4;
    localparam int DEV_REAR_A_BIT = 5;
    localparam int DEV_REAR_B_BIT = 6;
    localparam int DEV_KEY_BIT = 14;
    // Standard event bit set by the operation-complete command.
    localparam int ESR_OPC_BIT = 0;
    // Configuration register selects on the command port.
    localparam logic [2:0] SEL_OP_PTR = 3'h0;
    localparam logic [2:0] SEL_OP_NTR = 3'h1;
    localparam logic [2:0] SEL_OP_ENABLE = 3'h2;
    localparam logic [2:0] SEL_DEV_PTR = 3'h3;
    localparam logic [2:0] SEL_DEV_NTR = 3'h4;
    localparam logic [2:0] SEL_DEV_ENABLE = 3'h5;
    // Reset values of the filters and enables.
    localparam logic [15:0] PTR_RESET = 16'hffff;
    localparam logic [15:0] NTR_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    // Condition bits that may ever be set in each group.
    localparam logic [15:0] OP_USED_MASK = 16'h1c31;
    localparam logic [15:0] DEV_USED_MASK = 16'h007e;
    // Reply byte of the operation-complete query, ASCII one.
    localparam logic [7:0] OPC_REPLY_CHAR = 8'h31;
endpackage

// ==== design/msc_bank.sv ====
// Operation and device status groups with operation-complete signalling.
`timescale 1ns/1ns
module msc_bank (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Calibration sequencing pulses.
    input wire logic zero_start_in,
    input wire logic cal_start_in,
    input wire logic zero_cal_start_in,
    input wire logic cal_phase_end_in,
    // Measurement and trigger state pulses, limit result and sensor read levels.
    input wire logic meas_start_in,
    input wire logic meas_done_in,
    input wire logic lower_fail_in,
    input wire logic upper_fail_in,
    input wire logic trig_wait_enter_in,
    input wire logic trig_idle_enter_in,
    input wire logic sensor_mem_read_in,
    // Sensor detect pins, asynchronous.
    input wire logic sens_a_front_in,
    input wire logic sens_a_rear_in,
    input wire logic sens_b_front_in,
    input wire logic sens_b_rear_in,
    input wire logic sens_a_mem_fail_in,
    input wire logic sens_b_mem_fail_in,
    // Front panel key press pulse.
    input wire logic key_press_in,
    // Command port from the command parser.
    input wire logic cfg_wr_in,
    input wire logic [2:0] cfg_sel_in,
    input wire logic [15:0] cfg_data_in,
    input wire logic cls_in,
    input wire logic op_event_read_in,
    input wire logic dev_event_read_in,
    input wire logic esr_read_in,
    input wire logic opc_cmd_in,
    input wire logic opc_query_in,
    input wire logic cmds_pending_in,
    // Status readback.
    output logic [15:0] op_cond_out,
    output logic [15:0] op_event_out,
    output logic [15:0] dev_cond_out,
    output logic [15:0] dev_event_out,
    output logic op_summary_out,
    output logic dev_summary_out,
    output logic esr_opc_out,
    // Output queue entry of the completion query.
    output logic opc_reply_valid_out,
    output logic [7:0] opc_reply_data_out
);

    typedef enum logic [3:0] {
        MSC_CAL_IDLE = 4'b0001,
        MSC_CAL_SINGLE = 4'b0010,
        MSC_CAL_COMBO_ZERO = 4'b0100,
        MSC_CAL_COMBO_CAL = 4'b1000
    } msc_cal_e;

    msc_cal_e cal_state;
    msc_cal_e next_cal_state;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic measurement_in_progress;
    logic trig_waiting;
    logic lower_fail;
    logic upper_fail;
    logic [15:0] op_cond;
    logic [15:0] dev_cond;
    logic [15:0] op_cond_prev;
    logic [15:0] dev_cond_prev;
    logic [15:0] op_ptr;
    logic [15:0] op_ntr;
    logic [15:0] op_enable;
    logic [15:0] dev_ptr;
    logic [15:0] dev_ntr;
    logic [15:0] dev_enable;
    logic [15:0] key_event;
    logic opc_cmd_wait;
    logic opc_query_wait;

    // Transition filter: rising edges pass through ptr, falling through ntr.
    function automatic logic [15:0] msc_filter(input logic [15:0] prev, input logic [15:0] cur,
                                               input logic [15:0] ptr, input logic [15:0] ntr);
        msc_filter = ((~prev & cur) & ptr) | ((prev & ~cur) & ntr);
    endfunction

    // Detect pins come from the sensor connectors, so two flops before use.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= {sens_b_mem_fail_in, sens_a_mem_fail_in, sens_b_rear_in,
                         sens_b_front_in, sens_a_rear_in, sens_a_front_in};
            pin_sync <= pin_meta;
        end
    end

    // Calibrating sequencer; a combined run moves on to its cal phase at the end of its zero phase.
    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            MSC_CAL_IDLE: begin
                if (zero_cal_start_in) begin
                    next_cal_state = MSC_CAL_COMBO_ZERO;
                end else if (zero_start_in || cal_start_in) begin
                    next_cal_state = MSC_CAL_SINGLE;
                end
            end
            MSC_CAL_SINGLE: begin
                if (cal_phase_end_in) begin
                    next_cal_state = MSC_CAL_IDLE;
                end
            end
            MSC_CAL_COMBO_ZERO: begin
                if (cal_phase_end_in) begin
                    next_cal_state = MSC_CAL_COMBO_CAL;
                end
            end
            MSC_CAL_COMBO_CAL: begin
                if (cal_phase_end_in) begin
                    next_cal_state = MSC_CAL_IDLE;
                end
            end
            default: begin
                next_cal_state = MSC_CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cal_state <= MSC_CAL_IDLE;
        end else begin
            cal_state <= next_cal_state;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            measurement_in_progress <= 1'b0;
        end else if (meas_start_in) begin
            measurement_in_progress <= 1'b1;
        end else if (meas_done_in) begin
            measurement_in_progress <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            trig_waiting <= 1'b0;
        end else if (trig_wait_enter_in) begin
            trig_waiting <= 1'b1;
        end else if (trig_idle_enter_in) begin
            trig_waiting <= 1'b0;
        end
    end

    // limit results
    // The fail inputs already read low when a test is disabled.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            lower_fail <= 1'b0;
            upper_fail <= 1'b0;
        end else if (meas_done_in) begin
            lower_fail <= lower_fail_in;
            upper_fail <= upper_fail_in;
        end
    end

    // Condition words; unused bits and bit 15 stay zero.
    always_comb begin
        op_cond = 16'h0000;
        op_cond[msc_pkg::OP_CAL_BIT] = (cal_state != MSC_CAL_IDLE);
        op_cond[msc_pkg::OP_MEAS_BIT] = measurement_in_progress;
        op_cond[msc_pkg::OP_TRIG_BIT] = trig_waiting;
        op_cond[msc_pkg::OP_SENSE_BIT] = sensor_mem_read_in;
        op_cond[msc_pkg::OP_LOWER_BIT] = lower_fail;
        op_cond[msc_pkg::OP_UPPER_BIT] = upper_fail;
        dev_cond = 16'h0000;
        dev_cond[msc_pkg::DEV_CONN_A_BIT] = pin_sync[0] | pin_sync[1];
        dev_cond[msc_pkg::DEV_CONN_B_BIT] = pin_sync[2] | pin_sync[3];
        dev_cond[msc_pkg::DEV_ERR_A_BIT] = pin_sync[4] | (pin_sync[0] & pin_sync[1]);
        dev_cond[msc_pkg::DEV_ERR_B_BIT] = pin_sync[5] | (pin_sync[2] & pin_sync[3]);
        dev_cond[msc_pkg::DEV_REAR_A_BIT] = pin_sync[1];
        dev_cond[msc_pkg::DEV_REAR_B_BIT] = pin_sync[3];
    end

    // Filter and enable registers written from the command port.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            op_ptr <= msc_pkg::PTR_RESET;
            op_ntr <= msc_pkg::NTR_RESET;
            op_enable <= msc_pkg::ENABLE_RESET;
            dev_ptr <= msc_pkg::PTR_RESET;
            dev_ntr <= msc_pkg::NTR_RESET;
            dev_enable <= msc_pkg::ENABLE_RESET;
        end else if (cfg_wr_in) begin
            case (cfg_sel_in)
                msc_pkg::SEL_OP_PTR: op_ptr <= cfg_data_in;
                msc_pkg::SEL_OP_NTR: op_ntr <= cfg_data_in;
                msc_pkg::SEL_OP_ENABLE: op_enable <= cfg_data_in;
                msc_pkg::SEL_DEV_PTR: dev_ptr <= cfg_data_in;
                msc_pkg::SEL_DEV_NTR: dev_ntr <= cfg_data_in;
                msc_pkg::SEL_DEV_ENABLE: dev_enable <= cfg_data_in;
                default: begin
                end
            endcase
        end
    end

    // Previous conditions for edge detection.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            op_cond_prev <= 16'h0000;
            dev_cond_prev <= 16'h0000;
        end else begin
            op_cond_prev <= op_cond;
            dev_cond_prev <= dev_cond;
        end
    end

    always_comb begin
        key_event = 16'h0000;
        key_event[msc_pkg::DEV_KEY_BIT] = key_press_in;
    end

    // sticky event latch
    // A new event in the clearing cycle survives, since set wins over clear.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            op_event_out <= 16'h0000;
            dev_event_out <= 16'h0000;
        end else begin
            op_event_out <= ((op_event_out & ~{16{op_event_read_in | cls_in}})
                             | msc_filter(op_cond_prev, op_cond, op_ptr, op_ntr))
                            & msc_pkg::OP_USED_MASK;
            dev_event_out <= (dev_event_out & ~{16{dev_event_read_in | cls_in}})
                             | (msc_filter(dev_cond_prev, dev_cond, dev_ptr, dev_ntr)
                                & msc_pkg::DEV_USED_MASK)
                             | key_event;
        end
    end

    // Registered condition and summary outputs.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            op_cond_out <= 16'h0000;
            dev_cond_out <= 16'h0000;
            op_summary_out <= 1'b0;
            dev_summary_out <= 1'b0;
        end else begin
            op_cond_out <= op_cond;
            dev_cond_out <= dev_cond;
            op_summary_out <= |(op_event_out & op_enable);
            dev_summary_out <= |(dev_event_out & dev_enable);
        end
    end

    // Pending completion requests wait until the parser reports no pending work.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            opc_cmd_wait <= 1'b0;
            opc_query_wait <= 1'b0;
        end else begin
            opc_cmd_wait <= opc_cmd_in | (opc_cmd_wait & cmds_pending_in);
            opc_query_wait <= opc_query_in | (opc_query_wait & cmds_pending_in);
        end
    end

    // clear on status clear or read
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            esr_opc_out <= 1'b0;
        end else if (opc_cmd_wait && !cmds_pending_in) begin
            esr_opc_out <= 1'b1;
        end else if (cls_in || esr_read_in) begin
            esr_opc_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            opc_reply_valid_out <= 1'b0;
            opc_reply_data_out <= 8'h00;
        end else begin
            opc_reply_valid_out <= opc_query_wait & ~cmds_pending_in;
            opc_reply_data_out <= msc_pkg::OPC_REPLY_CHAR;
        end
    end

endmodule

// ==== sim/msc_bank_properties.sv ====
// Checker of the status bank port relations.
`timescale 1ns/1ns
module msc_bank_properties (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Inputs that cause condition, key event and completion changes.
    input wire logic zero_start_in,
    input wire logic cal_phase_end_in,
    input wire logic meas_start_in,
    input wire logic meas_done_in,
    input wire logic lower_fail_in,
    input wire logic trig_wait_enter_in,
    input wire logic sensor_mem_read_in,
    input wire logic sens_a_rear_in,
    input wire logic key_press_in,
    input wire logic cmds_pending_in,
    input wire logic opc_cmd_in,
    // Outputs under watch.
    input wire logic [15:0] op_cond_out,
    input wire logic [15:0] dev_cond_out,
    input wire logic [15:0] dev_event_out,
    input wire logic esr_opc_out,
    input wire logic opc_reply_valid_out,
    input wire logic [7:0] opc_reply_data_out
);
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // An end pulse next to the start may win, so it is excluded.
    property p_cal;
        zero_start_in && !cal_phase_end_in ##1 !cal_phase_end_in |-> ##1 op_cond_out[0];
    endproperty
    a_cal: assert property (p_cal) else $error("calibrating bit not set");
    property p_meas; meas_start_in |-> ##2 op_cond_out[4]; endproperty
    a_meas: assert property (p_meas) else $error("measurement_in_progress bit not set");
    property p_low;
        meas_done_in && !meas_start_in |-> ##2 op_cond_out[11] == $past(lower_fail_in, 2);
    endproperty
    a_low: assert property (p_low) else $error("lower limit bit wrong");
    property p_trig; trig_wait_enter_in |-> ##2 op_cond_out[5]; endproperty
    a_trig: assert property (p_trig) else $error("trigger wait bit not set");
    property p_sense; 1 ##1 1 |-> op_cond_out[10] == $past(sensor_mem_read_in); endproperty
    a_sense: assert property (p_sense) else $error("sensor read bit wrong");
    property p_unused;
        (op_cond_out & ~msc_pkg::OP_USED_MASK) == 16'h0000 && !dev_cond_out[14];
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    // The pin passes two sync stages and the output flop.
    property p_rear; 1 ##3 1 |-> dev_cond_out[5] == $past(sens_a_rear_in, 3); endproperty
    a_rear: assert property (p_rear) else $error("rear bit wrong");
    property p_key; key_press_in |=> dev_event_out[14]; endproperty
    a_key: assert property (p_key) else $error("key event not set");
    // A reply may only follow a cycle in which nothing was pending.
    property p_opc;
        opc_reply_valid_out |-> opc_reply_data_out == 8'h31 && !$past(cmds_pending_in);
    endproperty
    a_opc: assert property (p_opc) else $error("reply byte wrong");
    // The bit rises once the wait flag meets a quiet parser.
    property p_esr;
        opc_cmd_in && !cmds_pending_in ##1 !cmds_pending_in |=> esr_opc_out;
    endproperty
    a_esr: assert property (p_esr) else $error("completion bit not set");
    c_meas: cover property (meas_done_in);
    c_key: cover property (key_press_in);
    c_opc: cover property (opc_reply_valid_out);
endmodule
bind msc_bank msc_bank_properties i_props (.*);

// ==== sim/msc_ctrl_model.sv ====
// Bus controller model driving the command port of the status bank.
`timescale 1ns/1ns
module msc_ctrl_model (
    // Clock.
    input wire logic clk_in,
    // Strobes: clear, op read, dev read, event read, complete, complete query.
    output logic [5:0] strobe_out,
    // Configuration write and pending level.
    output logic cfg_wr_out,
    output logic [2:0] cfg_sel_out,
    output logic [15:0] cfg_data_out,
    output logic pending_out
);
    // Idle the port at time zero so the bank never sees unknowns.
    initial begin
        strobe_out = 6'h00;
        cfg_wr_out = 1'b0;
        cfg_sel_out = 3'h7;
        cfg_data_out = 16'h0000;
        pending_out = 1'b0;
    end
    // One-cycle strobe launched just after an edge.
    task automatic cmd(input int b);
        @(posedge clk_in);
        #10 strobe_out = 6'h01 << b;
        @(posedge clk_in);
        #10 strobe_out = 6'h00;
    endtask
    // Data is inverted after the write so stale values never look valid.
    task automatic cfg(input logic [2:0] sel, input logic [15:0] data);
        @(posedge clk_in);
        #10 cfg_wr_out = 1'b1;
        cfg_sel_out = sel;
        cfg_data_out = data;
        @(posedge clk_in);
        #10 cfg_wr_out = 1'b0;
        cfg_data_out = ~data;
    endtask
    task automatic set_pending(input logic v);
        pending_out = v;
    endtask
    task automatic start_up;
        cmd(0);
        cmd(5);
    endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the meter status condition bank.
`timescale 1ns/1ns
module tb;
    logic clk_sys_in, rst_in, lo, up, smr, cwr, pend;
    logic op_sum, dev_sum, esr, rv;
    logic [8:0] pl;
    logic [5:0] pn, st;
    logic [2:0] csel;
    logic [15:0] cdat, op_cond, op_ev, dev_cond, dev_ev;
    logic [15:0] nrep = 16'h0000;
    logic [7:0] rd;
    logic [5:0] pat [4] = '{6'h01, 6'h03, 6'h28, 6'h14};
    int num_errors = 0;
    int total_checks = 0;
    msc_ctrl_model i_ctrl (.clk_in(clk_sys_in), .strobe_out(st), .cfg_wr_out(cwr),
        .cfg_sel_out(csel), .cfg_data_out(cdat), .pending_out(pend));
    msc_bank i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .zero_start_in(pl[0]), .cal_start_in(pl[1]), .zero_cal_start_in(pl[2]),
        .cal_phase_end_in(pl[3]), .meas_start_in(pl[4]), .meas_done_in(pl[5]),
        .lower_fail_in(lo), .upper_fail_in(up), .trig_wait_enter_in(pl[6]),
        .trig_idle_enter_in(pl[7]), .sensor_mem_read_in(smr),
        .sens_a_front_in(pn[0]), .sens_a_rear_in(pn[1]), .sens_b_front_in(pn[2]),
        .sens_b_rear_in(pn[3]), .sens_a_mem_fail_in(pn[4]), .sens_b_mem_fail_in(pn[5]),
        .key_press_in(pl[8]), .cfg_wr_in(cwr), .cfg_sel_in(csel), .cfg_data_in(cdat),
        .cls_in(st[0]), .op_event_read_in(st[1]), .dev_event_read_in(st[2]),
        .esr_read_in(st[3]), .opc_cmd_in(st[4]), .opc_query_in(st[5]),
        .cmds_pending_in(pend), .op_cond_out(op_cond), .op_event_out(op_ev),
        .dev_cond_out(dev_cond), .dev_event_out(dev_ev), .op_summary_out(op_sum),
        .dev_summary_out(dev_sum), .esr_opc_out(esr), .opc_reply_valid_out(rv),
        .opc_reply_data_out(rd));
    // Free-running 100 ns clock.
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // Count reply pulses; a one-cycle pulse is seen at exactly one edge.
    always @(posedge clk_sys_in) if (rv === 1'b1) nrep <= nrep + 16'h0001;
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #10;
    endtask
    // Pulse one input, then wait until its condition bit can show.
    task automatic pulse(input int b);
        @(posedge clk_sys_in);
        #10 pl = 9'h001 << b;
        @(posedge clk_sys_in);
        #10 pl = 9'h000;
        step(2);
    endtask
    // Limit results and sensor read level, given as lower, upper, read.
    task automatic levels(input logic [2:0] v);
        lo = v[2];
        up = v[1];
        smr = v[0];
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] dexp(input logic [5:0] p);
        dexp = 16'h0000;
        dexp[6:1] = {p[3], p[1], p[5] | (p[2] & p[3]), p[4] | (p[0] & p[1]),
            p[2] | p[3], p[0] | p[1]};
    endfunction
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge clk_sys_in);
        num_errors++;
        close_out;
    end
    // Main sequence of tests.
    initial begin
        {pl, pn, lo, up, smr} = 18'h00000;
        rst_in = 1'b1;
        step(20);
        rst_in = 1'b0;
        step(1);
        chk(op_cond, 16'h0000);
        chk(dev_cond, 16'h0000);
        chk({8'h00, rd}, 16'h0031);
        i_ctrl.start_up();
        step(2);
        chk(nrep, 16'h0001);
        $display("test reset finished");
        pulse(0);
        chk(op_cond, 16'h0001);
        pulse(3);
        chk(op_cond, 16'h0000);
        pulse(2);
        chk(op_cond, 16'h0001);
        pulse(3);
        chk(op_cond, 16'h0001);
        pulse(3);
        chk(op_cond, 16'h0000);
        pulse(1);
        chk(op_cond, 16'h0001);
        pulse(3);
        chk(op_cond, 16'h0000);
        levels(3'b100);
        pulse(4);
        chk(op_cond, 16'h0010);
        pulse(5);
        chk(op_cond, 16'h0800);
        levels(3'b010);
        pulse(4);
        pulse(5);
        chk(op_cond, 16'h1000);
        levels(3'b000);
        pulse(4);
        pulse(5);
        chk(op_cond, 16'h0000);
        pulse(6);
        chk(op_cond, 16'h0020);
        pulse(7);
        chk(op_cond, 16'h0000);
        levels(3'b001);
        step(2);
        chk(op_cond, 16'h0400);
        levels(3'b000);
        step(2);
        chk(op_cond, 16'h0000);
        $display("test operation finished");
        chk(op_ev, 16'h1c31);
        i_ctrl.cmd(1);
        chk(op_ev, 16'h0000);
        i_ctrl.cfg(msc_pkg::SEL_OP_PTR, 16'h0000);
        i_ctrl.cfg(msc_pkg::SEL_OP_NTR, 16'h0010);
        i_ctrl.cfg(msc_pkg::SEL_OP_ENABLE, 16'h0010);
        pulse(4);
        chk({op_ev[14:0], op_sum}, 16'h0000);
        pulse(5);
        step(2);
        chk({op_ev[14:0], op_sum}, 16'h0021);
        $display("test events finished");
        for (int i = 0; i < 4; i++) begin
            pn = pat[i];
            step(4);
            chk(dev_cond, dexp(pat[i]));
        end
        pn = 6'h00;
        step(4);
        i_ctrl.cmd(2);
        i_ctrl.cfg(msc_pkg::SEL_DEV_PTR, 16'h0000);
        i_ctrl.cfg(msc_pkg::SEL_DEV_ENABLE, 16'h4000);
        pulse(8);
        chk({dev_ev[15:1], dev_sum}, 16'h4001);
        chk(dev_cond, 16'h0000);
        i_ctrl.cmd(2);
        chk(dev_ev, 16'h0000);
        // Of the condition edges, only the falling edge of channel A presence may latch now; a key press still latches.
        i_ctrl.cfg(msc_pkg::SEL_DEV_NTR, 16'h0002);
        pn = 6'h01;
        step(4);
        chk(dev_ev, 16'h0000);
        pn = 6'h00;
        step(4);
        chk(dev_ev, 16'h0002);
        chk({15'h0, dev_sum}, 16'h0000);
        $display("test device finished");
        i_ctrl.set_pending(1'b1);
        i_ctrl.cmd(5);
        step(4);
        chk(nrep, 16'h0001);
        i_ctrl.set_pending(1'b0);
        step(3);
        chk(nrep, 16'h0002);
        i_ctrl.set_pending(1'b1);
        i_ctrl.cmd(4);
        step(3);
        chk({15'h0, esr}, 16'h0000);
        i_ctrl.set_pending(1'b0);
        step(3);
        chk({15'h0, esr}, 16'h0001);
        i_ctrl.cmd(0);
        chk({15'h0, esr}, 16'h0000);
        i_ctrl.cmd(4);
        step(3);
        chk({15'h0, esr}, 16'h0001);
        i_ctrl.cmd(3);
        chk({15'h0, esr}, 16'h0000);
        $display("test completion finished");
        close_out;
    end
endmodule
